// File: rtl/gsq_params.svh
// Purpose: constants for the pin query block
// Assumes: 200 MHz core clock
// Notes: timing counts derive from rates in Hz
`ifndef GSQ_PARAMS_SVH
`define GSQ_PARAMS_SVH
`define GSQ_CLK_HZ 200_000_000
`define GSQ_SAMPLE_HZ 32
`define GSQ_SAMPLE_CYC (`GSQ_CLK_HZ / `GSQ_SAMPLE_HZ)
`define GSQ_PWM_HZ 100
`define GSQ_PWM_STEP_CYC (`GSQ_CLK_HZ / (`GSQ_PWM_HZ * 100))
`define GSQ_CMD_QUERY 8'h23
`define GSQ_REPLY_BIT 8'h40
`define GSQ_PIN_COUNT 5
`define GSQ_DUTY_MAX 8'h64
`define GSQ_DUTY_RST 8'h00
`define GSQ_FUNC_RST 4'h0
`define GSQ_REG_CTRL 4'h0
`define GSQ_REG_PIN_SEL 4'h1
`define GSQ_REG_CFG 4'h2
`define GSQ_REG_LEVELS 4'h3
`define GSQ_FLD_FUNC 3
`define GSQ_LVL_BIT 0
`define GSQ_FALL_BIT 1
`define GSQ_RISE_BIT 2
`endif

// File: rtl/gsq_pkg.sv
// Purpose: types for the pin query block
// Assumes: nothing
// Notes: constants live in gsq_params.svh
package gsq_pkg;
   typedef enum logic [1:0]
   {
      GSQ_IDLE = 2'b00,
      GSQ_HDR = 2'b01,
      GSQ_BODY = 2'b11
   } gsq_state_t;
endpackage

// File: rtl/gsq_pwm.sv
// Purpose: one pulse-width output at 100 Hz
// Assumes: duty already limited to 0..100
// Notes: 0 holds low, 100 holds high
`timescale 1ns/1ps
`include "gsq_params.svh"
module gsq_pwm
#(
   parameter int STEP_CYC = `GSQ_PWM_STEP_CYC
)
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] duty_i,
   output logic pwm_o
);
   logic [15:0] prescale;
   logic [15:0] next_prescale;
   logic [6:0] phase;
   logic [6:0] next_phase;
   logic next_pwm;

   always_comb
   begin
      next_prescale = prescale + 16'h0001;
      next_phase = phase;
      if (prescale == 16'(STEP_CYC - 1))
      begin
         next_prescale = 16'h0000;
         next_phase = (phase == 7'd99) ? 7'd0 : phase + 7'd1;
      end
      // Compare against phase makes 0 always low and 100 always high
      next_pwm = ({1'b0, phase} < duty_i);
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         prescale <= 16'h0000;
         phase <= 7'd0;
         pwm_o <= 1'b0;
      end
      else
      begin
         prescale <= next_prescale;
         phase <= next_phase;
         pwm_o <= next_pwm;
      end
   end
endmodule // gsq_pwm

// File: rtl/gsq_query.sv
// Function
// - Indices 0..4 valid, 5..255 reserved
// - Reply byte 0 echoes pin index
// - Byte 1 bit 0 is last sample
// - Byte 1 bit 1 is falling edge
// - Byte 1 bit 2 rising edge, rest zero
// - Pins sampled near 32 Hz, independently
// - Level is real input, not setting
// - Byte 2 returns duty 0..100
// - Byte 3 low bits drive mode
// - Byte 3 bit 3 function select
// - Byte 3 upper bits read zero
// - Reply type is command OR 0x40
// - 0 low, 100 high, between is PWM
//
// Purpose: answer pin-state queries arriving as byte stream on a packet link
// Assumes: framing/checksum removed upstream; pins come from outside the clock domain
// Notes: reply is type, then four payload bytes, one per cycle; reserved index replies zeros after the index byte
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "gsq_params.svh"
module gsq_query
   import gsq_pkg::*;
#(
   parameter int NPIN = `GSQ_PIN_COUNT,
   parameter int SAMPLE_CYC = `GSQ_SAMPLE_CYC
)
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [NPIN-1:0] pin_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_type_i,
   input wire logic [7:0] cmd_data_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic rsp_valid_o,
   output logic rsp_last_o,
   output logic [7:0] rsp_data_o,
   output logic [NPIN-1:0] pwm_o
);
   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and periodic sampling
   logic [NPIN-1:0] pin_meta;
   logic [NPIN-1:0] pin_sync;
   logic [NPIN-1:0] level;
   logic [NPIN-1:0] next_level;
   logic [NPIN-1:0] rise;
   logic [NPIN-1:0] next_rise;
   logic [NPIN-1:0] fall;
   logic [NPIN-1:0] next_fall;
   logic [31:0] tick_cnt;
   logic [31:0] next_tick_cnt;
   logic tick;

   ////////////////////////////////////////////////////////////////////////
   // Settings registers and query state
   logic [7:0] duty [NPIN];
   logic [7:0] next_duty [NPIN];
   logic [3:0] func_drive [NPIN];
   logic [3:0] next_func_drive [NPIN];
   logic [7:0] pin_sel;
   logic [7:0] next_pin_sel;
   gsq_state_t state;
   gsq_state_t next_state;
   logic [7:0] q_type;
   logic [7:0] next_q_type;
   logic [7:0] q_idx;
   logic [7:0] next_q_idx;
   logic [1:0] byte_cnt;
   logic [1:0] next_byte_cnt;
   logic next_rsp_valid;
   logic next_rsp_last;
   logic [7:0] next_rsp_data;
   logic [7:0] next_reg_rdata;
   logic clr_req;

   function automatic logic idx_ok(input logic [7:0] idx);
      idx_ok = (idx < 8'(NPIN));
   endfunction

   function automatic logic [7:0] sat_duty(input logic [7:0] d);
      sat_duty = (d > `GSQ_DUTY_MAX) ? `GSQ_DUTY_MAX : d;
   endfunction

   assign tick = (tick_cnt == 32'(SAMPLE_CYC - 1));

   // Clear strobe for the queried pin, issued as the status byte leaves
   assign clr_req = (state == GSQ_BODY) && (byte_cnt == 2'd1) && idx_ok(q_idx);

   always_comb
   begin
      next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      next_level = level;
      next_rise = rise;
      next_fall = fall;
      for (int i = 0; i < NPIN; i++)
      begin
         if (clr_req && (q_idx[2:0] == 3'(i)))
         begin
            next_rise[i] = 1'b0;
            next_fall[i] = 1'b0;
         end
         if (tick)
         begin
            // Sample the real pin, not the driven value
            next_level[i] = pin_sync[i];
            // A new edge wins over a clear in the same cycle
            if (pin_sync[i] && !level[i])
            begin
               next_rise[i] = 1'b1;
            end
            if (!pin_sync[i] && level[i])
            begin
               next_fall[i] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
         level <= '0;
         rise <= '0;
         fall <= '0;
         tick_cnt <= 32'h0000_0000;
      end
      else
      begin
         pin_meta <= pin_i;
         pin_sync <= pin_meta;
         level <= next_level;
         rise <= next_rise;
         fall <= next_fall;
         tick_cnt <= next_tick_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register port: select a pin, then write its duty and function/drive
   always_comb
   begin
      next_pin_sel = pin_sel;
      next_reg_rdata = 8'h00;
      for (int i = 0; i < NPIN; i++)
      begin
         next_duty[i] = duty[i];
         next_func_drive[i] = func_drive[i];
      end
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            `GSQ_REG_PIN_SEL:
            begin
               next_pin_sel = reg_wdata_i;
            end
            `GSQ_REG_CTRL:
            begin
               if (idx_ok(pin_sel))
               begin
                  next_duty[pin_sel[2:0]] = sat_duty(reg_wdata_i);
               end
            end
            `GSQ_REG_CFG:
            begin
               if (idx_ok(pin_sel))
               begin
                  next_func_drive[pin_sel[2:0]] = reg_wdata_i[3:0];
               end
            end
            default:
            begin
            end
         endcase
      end
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            `GSQ_REG_PIN_SEL: next_reg_rdata = pin_sel;
            `GSQ_REG_CTRL: next_reg_rdata = idx_ok(pin_sel) ? duty[pin_sel[2:0]] : 8'h00;
            `GSQ_REG_CFG: next_reg_rdata = idx_ok(pin_sel) ? {4'h0, func_drive[pin_sel[2:0]]} : 8'h00;
            `GSQ_REG_LEVELS: next_reg_rdata = 8'(level);
            default: next_reg_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         pin_sel <= 8'h00;
         reg_rdata_o <= 8'h00;
         for (int i = 0; i < NPIN; i++)
         begin
            duty[i] <= `GSQ_DUTY_RST;
            func_drive[i] <= `GSQ_FUNC_RST;
         end
      end
      else
      begin
         pin_sel <= next_pin_sel;
         reg_rdata_o <= next_reg_rdata;
         for (int i = 0; i < NPIN; i++)
         begin
            duty[i] <= next_duty[i];
            func_drive[i] <= next_func_drive[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Query decode and reply sequencing
   always_comb
   begin
      next_state = state;
      next_q_type = q_type;
      next_q_idx = q_idx;
      next_byte_cnt = byte_cnt;
      next_rsp_valid = 1'b0;
      next_rsp_last = 1'b0;
      next_rsp_data = 8'h00;
      unique case (state)
         GSQ_IDLE:
         begin
            // Other command codes belong to other blocks and are ignored
            if (cmd_valid_i && (cmd_type_i == `GSQ_CMD_QUERY))
            begin
               next_q_type = cmd_type_i;
               next_q_idx = cmd_data_i;
               next_state = GSQ_HDR;
            end
         end
         GSQ_HDR:
         begin
            next_rsp_valid = 1'b1;
            next_rsp_data = q_type | `GSQ_REPLY_BIT;
            next_byte_cnt = 2'd0;
            next_state = GSQ_BODY;
         end
         GSQ_BODY:
         begin
            next_rsp_valid = 1'b1;
            next_byte_cnt = byte_cnt + 2'd1;
            unique case (byte_cnt)
               2'd0: next_rsp_data = q_idx;
               2'd1:
               begin
                  if (idx_ok(q_idx))
                  begin
                     // Upper bits reserved, returned as zero
                     next_rsp_data = {5'b0_0000, rise[q_idx[2:0]], fall[q_idx[2:0]], level[q_idx[2:0]]};
                  end
               end
               2'd2:
               begin
                  if (idx_ok(q_idx))
                  begin
                     next_rsp_data = duty[q_idx[2:0]];
                  end
               end
               2'd3:
               begin
                  next_rsp_last = 1'b1;
                  next_state = GSQ_IDLE;
                  if (idx_ok(q_idx))
                  begin
                     next_rsp_data = {4'h0, func_drive[q_idx[2:0]]};
                  end
               end
            endcase
         end
         default:
         begin
            next_state = GSQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         state <= GSQ_IDLE;
         q_type <= 8'h00;
         q_idx <= 8'h00;
         byte_cnt <= 2'd0;
         rsp_valid_o <= 1'b0;
         rsp_last_o <= 1'b0;
         rsp_data_o <= 8'h00;
      end
      else
      begin
         state <= next_state;
         q_type <= next_q_type;
         q_idx <= next_q_idx;
         byte_cnt <= next_byte_cnt;
         rsp_valid_o <= next_rsp_valid;
         rsp_last_o <= next_rsp_last;
         rsp_data_o <= next_rsp_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pulse-width outputs, one per pin
   for (genvar g = 0; g < NPIN; g++)
   begin : g_pwm
      gsq_pwm u_pwm
      (
         .core_clk_i(core_clk_i),
         .sys_rst_i(sys_rst_i),
         .duty_i(duty[g]),
         .pwm_o(pwm_o[g])
      );
   end
endmodule // gsq_query

// File: verif/gsq_query_properties.sv
// Purpose: reply framing checks for the pin query block
// Assumes: sync reset, one clock
// Notes: cnt mirrors the reply slot, 0 = idle
`timescale 1ns/1ps
module gsq_query_props
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_type_i,
   input wire logic [7:0] cmd_data_i,
   input wire logic rsp_valid_o,
   input wire logic rsp_last_o,
   input wire logic [7:0] rsp_data_o
);
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic acc;
   // Design is idle again while the last reply byte stands, so a query may be taken there
   assign acc = cmd_valid_i && cmd_type_i == 8'h23 && (cnt == 3'h0 || cnt == 3'h6);
   always_comb
   begin
      next_cnt = cnt + 3'h1;
      if (cnt == 3'h0 || cnt == 3'h6)
      begin
         next_cnt = {2'h0, acc};
      end
   end
   always_ff @(posedge core_clk_i)
      cnt <= sys_rst_i ? 3'h0 : next_cnt;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence head_s;
      rsp_data_o == 8'h63 ##1 rsp_data_o == $past(cmd_data_i, 3);
   endsequence
   sequence burst_s;
      rsp_valid_o[*5] ##1 !rsp_valid_o;
   endsequence
   a_reply_head: assert property (acc |-> ##2 head_s)
      else $error("reply type or index wrong");
   a_reply_len: assert property (acc |-> ##2 burst_s)
      else $error("reply length wrong");
   a_last_slot: assert property (rsp_last_o == (cnt == 3'h6))
      else $error("last flag misplaced");
   a_quiet_idle: assert property (cnt <= 3'h1 |-> !rsp_valid_o)
      else $error("reply without accepted query");
   a_status_upper: assert property (cnt == 3'h4 |-> rsp_data_o[7:3] == 5'h00)
      else $error("status upper bits set");
   a_duty_range: assert property (cnt == 3'h5 |-> rsp_data_o <= 8'h64)
      else $error("duty above 100");
   a_fd_upper: assert property (cnt == 3'h6 |-> rsp_data_o[7:4] == 4'h0)
      else $error("function byte upper bits set");
   a_reserved_zero: assert property (acc && cmd_data_i >= 8'h05 |-> ##4 (rsp_data_o == 8'h00)[*3])
      else $error("reserved index reply not zero");
endmodule // gsq_query_props
bind gsq_query gsq_query_props u_props
(
   .core_clk_i(core_clk_i),
   .sys_rst_i(sys_rst_i),
   .cmd_valid_i(cmd_valid_i),
   .cmd_type_i(cmd_type_i),
   .cmd_data_i(cmd_data_i),
   .rsp_valid_o(rsp_valid_o),
   .rsp_last_o(rsp_last_o),
   .rsp_data_o(rsp_data_o)
);

// File: verif/gsq_host_model.sv
// Purpose: host side that issues query commands
// Assumes: go_i is a request from the bench, one command for each cycle it stays high
// Notes: idle bytes invert so a stale byte never looks fresh
`timescale 1ns/1ps
module gsq_host_model
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic go_i,
   input wire logic [7:0] code_i,
   input wire logic [7:0] idx_i,
   output logic cmd_valid_o,
   output logic [7:0] cmd_type_o,
   output logic [7:0] cmd_data_o
);
   always_ff @(posedge core_clk_i)
   begin
      cmd_valid_o <= go_i && !sys_rst_i;
      cmd_type_o <= sys_rst_i ? 8'h00 : (go_i ? code_i : ~cmd_type_o);
      // Reserved index goes out only when the bench asks for it
      cmd_data_o <= sys_rst_i ? 8'h00 : (go_i ? idx_i : ~cmd_data_o);
   end
endmodule // gsq_host_model

// File: verif/tb_top.sv
// Purpose: directed bench for the pin query block
// Assumes: sample period shortened to 20 cycles
// Notes: waits of 60 cycles cover sync flops plus two samples
`timescale 1ns/1ps
module tb_top;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [4:0] pin_i = 5'h00;
   logic go = 1'b0;
   logic [7:0] code = 8'h00, idx = 8'h00;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic cmd_valid, rsp_valid, rsp_last;
   logic [7:0] cmd_type, cmd_data, reg_rdata, rsp_data;
   logic [4:0] pwm;
   logic [7:0] got [0:4];
   int fails = 0, samples_checked = 0, cyc = 0;
   always #2.5 core_clk_i = ~core_clk_i;
   gsq_host_model host (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .go_i(go), .code_i(code),
      .idx_i(idx), .cmd_valid_o(cmd_valid), .cmd_type_o(cmd_type), .cmd_data_o(cmd_data));
   gsq_query #(.SAMPLE_CYC(20)) dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .pin_i(pin_i),
      .cmd_valid_i(cmd_valid), .cmd_type_i(cmd_type), .cmd_data_i(cmd_data), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
      .rsp_valid_o(rsp_valid), .rsp_last_o(rsp_last), .rsp_data_o(rsp_data), .pwm_o(pwm));
   ////////////////////////////////////////
   task close_out();
      if (fails == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task cmp(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk_i);
      reg_wr <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk_i);
      reg_rd <= 1'b0;
      #1 cmp(reg_rdata, e);
      @(posedge core_clk_i);
   endtask
   task send(input logic [7:0] c, input logic [7:0] i);
      go <= 1'b1;
      code <= c;
      idx <= i;
      @(posedge core_clk_i);
      go <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task collect();
      int n;
      n = 0;
      do
      begin
         @(posedge core_clk_i);
         #1 n++;
      end
      while (rsp_valid !== 1'b1 && n < 8);
      for (int k = 0; k < 5; k++)
      begin
         got[k] = rsp_data;
         @(posedge core_clk_i);
         #1;
      end
      @(posedge core_clk_i);
   endtask
   task query(input logic [7:0] i, input logic [7:0] st, input logic [7:0] du, input logic [7:0] fd);
      send(8'h23, i);
      collect();
      cmp(got[0], 8'h63);
      cmp(got[1], i);
      cmp(got[2], st);
      cmp(got[3], du);
      cmp(got[4], fd);
   endtask
   task quiet();
      logic seen;
      seen = 1'b0;
      repeat (10)
      begin
         @(posedge core_clk_i);
         #1 seen = seen | rsp_valid;
      end
      cmp({7'h00, seen}, 8'h00);
      @(posedge core_clk_i);
   endtask
   ////////////////////////////////////////
   always @(posedge core_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         fails++;
         close_out();
      end
   end
   initial
   begin
      int n;
      repeat (5) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(4'h0, 8'h00);
      wr(4'h1, 8'h02);
      wr(4'h0, 8'h32);
      wr(4'h2, 8'hFB);
      rd(4'h0, 8'h32);
      rd(4'h2, 8'h0B);
      rd(4'hF, 8'h00);
      wr(4'h1, 8'h01);
      wr(4'h0, 8'hC8);
      rd(4'h0, 8'h64);
      query(8'h02, 8'h00, 8'h32, 8'h0B);
      query(8'h01, 8'h00, 8'h64, 8'h00);
      // Look between edges so the registered drive has settled
      #1;
      for (n = 0; n < 50 && pwm[1] !== 1'b1; n++)
         #5;
      cmp({7'h00, pwm[1]}, 8'h01);
      cmp({7'h00, pwm[0]}, 8'h00);
      // Half duty opens its period high
      cmp({7'h00, pwm[2]}, 8'h01);
      @(posedge core_clk_i);
      pin_i[0] <= 1'b1;
      pin_i[4] <= 1'b1;
      repeat (60) @(posedge core_clk_i);
      pin_i[4] <= 1'b0;
      repeat (60) @(posedge core_clk_i);
      query(8'h00, 8'h05, 8'h00, 8'h00);
      query(8'h00, 8'h01, 8'h00, 8'h00);
      query(8'h04, 8'h06, 8'h00, 8'h00);
      pin_i[0] <= 1'b0;
      repeat (60) @(posedge core_clk_i);
      query(8'h00, 8'h02, 8'h00, 8'h00);
      wr(4'h1, 8'h03);
      for (int m = 0; m < 16; m++)
      begin
         wr(4'h2, 8'(m));
         query(8'h03, 8'h00, 8'h00, 8'(m));
      end
      query(8'h05, 8'h00, 8'h00, 8'h00);
      query(8'hFF, 8'h00, 8'h00, 8'h00);
      send(8'h22, 8'h00);
      quiet();
      // Second query right behind the first lands before the reply starts and must be dropped
      go <= 1'b1;
      code <= 8'h23;
      idx <= 8'h01;
      @(posedge core_clk_i);
      idx <= 8'h04;
      @(posedge core_clk_i);
      go <= 1'b0;
      collect();
      cmp(got[0], 8'h63);
      cmp(got[1], 8'h01);
      cmp(got[3], 8'h64);
      quiet();
      // Reset in mid-run returns settings and drive to their rest values
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      wr(4'h1, 8'h01);
      rd(4'h0, 8'h00);
      #1 cmp({7'h00, pwm[1]}, 8'h00);
      @(posedge core_clk_i);
      query(8'h01, 8'h00, 8'h00, 8'h00);
      close_out();
   end
endmodule // tb_top
